// ---- hdl/snc_buf2.sv ----
`timescale 1ns/100ps
module snc_buf2 import snc_pkg::*; #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] n_q, n_d;
  logic push, pop;

  assign in_ready_o = (n_q != (AW+1)'(DEPTH));
  assign out_valid_o = (n_q != '0);
  assign out_data_o = mem_q[rp_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointer and count update
  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    if (push) begin
      mem_d[wp_q] = in_data_i;
      wp_d = (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
    end
    n_d = n_q + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_i) begin
      wp_d = '0;
      rp_d = '0;
      n_d = '0;
    end
  end

  // Storage registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wp_q <= '0;
      rp_q <= '0;
      n_q <= '0;
    end else begin
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      n_q <= n_d;
    end
  end
endmodule

// ---- hdl/snc_core.sv ----
// What this block does
// - Two-bit ECC result: clean, fixed, uncorrected
// - Reset command clears ECC result
// - ECC result meaningless while ECC disabled
// - Power-on loads ECC from page zero read
// - Failed or protected program/erase sets fail flag
// - Execute, erase or reset clear fail flags
// - Write-enable opcode sets write latch
// - Latch cleared by disable, power-up, execute, erase
// - Busy high during power-up and operations
// - Busy discards all but get-feature, reset, ID
// - Drive field selects pad strength
// - Feature get/set: address then data byte
// - Page read: dummy byte, row, then busy
// - Cache read: dummy nibble, column, dummy byte, then data
// - Dual read: two-line column, dummy, data
// - Quad read: four-line column, dummy, data
// - Every field shifts most significant first
// - Feature settings survive reset command
// - Status register not writable by set-feature
// - Chip select high ends the command
`timescale 1ns/100ps
module snc_core import snc_pkg::*; #(
  parameter logic [7:0] MFR_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'h3c, // Arbitrary value
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  // Serial link
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic [3:0] DQ_I,
  output logic [3:0] DQ_O,
  output logic [3:0] DQ_OE_O,
  // Array engine
  output logic ARR_START_O,
  output logic [1:0] ARR_OP_O,
  output logic [15:0] ARR_ROW_O,
  input wire logic ARR_DONE_I,
  input wire logic ARR_FAIL_I,
  input wire logic [1:0] ARR_ECC_I,
  // Cache read stream
  output logic [11:0] CACHE_COL_O,
  input wire logic [7:0] CACHE_DATA_I,
  input wire logic CACHE_VALID_I,
  output logic CACHE_READY_O,
  // Feature outputs
  output logic [1:0] DRIVE_STRENGTH_O,
  output logic ECC_ENABLE_O,
  output logic [7:0] PROTECT_CFG_O
);
  // --------------------------------------------------------------
  // Link sampling
  // --------------------------------------------------------------
  logic [5:0] pins_s;
  logic sclk_s, cs_n_s, sclk_q, rise, fall;
  logic [3:0] dq_s;

  snc_sync2 #(.W(6), .RST(6'h02)) u_sync (
    .clk_i(CLOCK_I),
    .arst_n_i(ARST_N_I),
    .d_i({DQ_I, CS_N_I, SCLK_I}),
    .q_o(pins_s)
  );
  assign sclk_s = pins_s[0];
  assign cs_n_s = pins_s[1];
  assign dq_s = pins_s[5:2];
  assign rise = sclk_s && !sclk_q;
  assign fall = !sclk_s && sclk_q;

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  snc_phase_t ph_q, ph_d;
  snc_aop_t aop_q, aop_d;
  logic [4:0] cnt_q, cnt_d, ln_q, ln_d;
  logic [23:0] sh_q, sh_d, nsh;
  logic [7:0] opc_q, opc_d, adr_q, adr_d, oreg_q, oreg_d, obyte;
  logic [3:0] obit_q, obit_d, dqo_q, dqo_d, oe_q, oe_d;
  logic [11:0] col_q, col_d;
  logic [15:0] row_q, row_d;
  logic [7:0] prot_q, prot_d, cfg_q, cfg_d, drv_q, drv_d;
  logic [1:0] ecc_q, ecc_d;
  logic pfail_q, pfail_d, efail_q, efail_d;
  logic write_enable_latch_q, write_enable_latch_d;
  logic busy_q, busy_d, start_q, start_d, boot_q, boot_d;
  logic idsel_q, idsel_d;
  logic last, cmd_go, launch, rd_op, rd_act, pop, wr_stb;
  logic [7:0] code;
  logic buf_v, buf_rdy;
  logic [7:0] buf_dat;
  logic [7:0] status;

  assign status = {2'h0, ecc_q, pfail_q, efail_q, write_enable_latch_q,
                   busy_q};
  assign rd_op = (opc_q == OP_RC1) || (opc_q == OP_RCF) ||
                 (opc_q == OP_RC2) || (opc_q == OP_RC4) ||
                 (opc_q == OP_RCD) || (opc_q == OP_RCQ);
  assign rd_act = rd_op && !cs_n_s &&
                  ((ph_q == PH_DUMMY) || (ph_q == PH_OUT));
  assign last = rise && (cnt_q <= ln_q);
  assign code = nsh[7:0];

  // Feature readback by address
  function automatic logic [7:0] rd_feat(input logic [7:0] a,
                                         input logic [7:0] p,
                                         input logic [7:0] c,
                                         input logic [7:0] s,
                                         input logic [7:0] d);
    case (a)
      ADR_PROT: rd_feat = p;
      ADR_CFG: rd_feat = c;
      ADR_STAT: rd_feat = s;
      ADR_DRV: rd_feat = d;
      default: rd_feat = 8'h00;
    endcase
  endfunction

  // --------------------------------------------------------------
  // Cache stream buffer
  // --------------------------------------------------------------
  snc_buf2 #(.W(8), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_i(CLOCK_I),
    .arst_n_i(ARST_N_I),
    .flush_i(!rd_act),
    .in_valid_i(CACHE_VALID_I && rd_act),
    .in_ready_o(buf_rdy),
    .in_data_i(CACHE_DATA_I),
    .out_valid_o(buf_v),
    .out_ready_i(pop),
    .out_data_o(buf_dat)
  );
  assign CACHE_READY_O = buf_rdy && rd_act;

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------
  always_comb begin
    ph_d = ph_q;
    aop_d = aop_q;
    cnt_d = cnt_q;
    ln_d = ln_q;
    sh_d = sh_q;
    opc_d = opc_q;
    adr_d = adr_q;
    oreg_d = oreg_q;
    obit_d = obit_q;
    dqo_d = dqo_q;
    col_d = col_q;
    row_d = row_q;
    prot_d = prot_q;
    cfg_d = cfg_q;
    drv_d = drv_q;
    ecc_d = ecc_q;
    pfail_d = pfail_q;
    efail_d = efail_q;
    write_enable_latch_d = write_enable_latch_q;
    idsel_d = idsel_q;
    boot_d = 1'b0;
    launch = 1'b0;
    pop = 1'b0;
    wr_stb = 1'b0;
    cmd_go = 1'b0;
    obyte = oreg_q;
    // Shift in, top line first
    case (ln_q)
      5'h02: nsh = {sh_q[21:0], dq_s[1:0]};
      5'h04: nsh = {sh_q[19:0], dq_s};
      default: nsh = {sh_q[22:0], dq_s[0]};
    endcase
    // Power-on read of the first page
    if (boot_q) begin
      launch = 1'b1;
      aop_d = AOP_READ;
      row_d = BOOT_ROW;
    end
    if (cs_n_s) begin
      ph_d = PH_CMD;
      cnt_d = BITS_OPC;
      ln_d = 5'h01;
      obit_d = 4'h0;
    end else if (rise && (ph_q != PH_OUT) && (ph_q != PH_IGN)) begin
      sh_d = nsh;
      cnt_d = cnt_q - ln_q;
      if (last) begin
        case (ph_q)
          PH_CMD: begin
            cmd_go = 1'b1;
            opc_d = code;
            ph_d = PH_IGN;
            if (busy_q && (code != OP_GETF) && (code != OP_RST) &&
                (code != OP_RDID)) begin
              ph_d = PH_IGN;
            end else begin
              case (code)
                OP_WRITE_ENABLE_CMD: write_enable_latch_d = 1'b1;
                OP_WRITE_DISABLE_CMD: write_enable_latch_d = 1'b0;
                OP_RST: begin
                  launch = 1'b1;
                  aop_d = AOP_RESET;
                  ecc_d = ECC_CLEAN;
                  pfail_d = 1'b0;
                  efail_d = 1'b0;
                end
                OP_GETF, OP_SETF: begin
                  ph_d = PH_ADDR;
                  cnt_d = BITS_FADR;
                end
                OP_PRD, OP_PEXE, OP_BERS: begin
                  ph_d = PH_ADDR;
                  cnt_d = BITS_ROW;
                end
                OP_RC1, OP_RCF, OP_RC2, OP_RC4: begin
                  ph_d = PH_ADDR;
                  cnt_d = BITS_COL;
                end
                OP_RCD: begin
                  ph_d = PH_ADDR;
                  cnt_d = BITS_COL;
                  ln_d = 5'h02;
                end
                OP_RCQ: begin
                  ph_d = PH_ADDR;
                  cnt_d = BITS_COL;
                  ln_d = 5'h04;
                end
                OP_RDID: begin
                  ph_d = PH_DUMMY;
                  cnt_d = BITS_DUM8;
                end
                default: ph_d = PH_IGN;
              endcase
            end
          end
          PH_ADDR: begin
            adr_d = code;
            ph_d = PH_IGN;
            if (opc_q == OP_GETF) begin
              ph_d = PH_OUT;
            end else if (opc_q == OP_SETF) begin
              ph_d = PH_WDATA;
              cnt_d = BITS_FADR;
            end else if (!rd_op) begin
              // Execute and erase need the latch set
              if ((opc_q == OP_PRD) || write_enable_latch_q) begin
                launch = 1'b1;
                row_d = nsh[15:0];
                case (opc_q)
                  OP_PEXE: aop_d = AOP_PROG;
                  OP_BERS: aop_d = AOP_ERASE;
                  default: aop_d = AOP_READ;
                endcase
                if (opc_q != OP_PRD) begin
                  pfail_d = 1'b0;
                  efail_d = 1'b0;
                end
              end
            end else begin
              // Column clamps to the last cache byte
              col_d = (nsh[11:0] > LAST_COL) ? LAST_COL
                                             : nsh[11:0];
              ph_d = PH_DUMMY;
              cnt_d = (opc_q == OP_RCQ) ? BITS_DUM16 : BITS_DUM8;
            end
          end
          PH_DUMMY: begin
            ph_d = PH_OUT;
            case (opc_q)
              OP_RC2, OP_RCD: ln_d = 5'h02;
              OP_RC4, OP_RCQ: ln_d = 5'h04;
              default: ln_d = 5'h01;
            endcase
          end
          PH_WDATA: begin
            wr_stb = 1'b1;
            ph_d = PH_IGN;
            case (adr_q)
              ADR_PROT: prot_d = code;
              ADR_CFG: cfg_d = code;
              ADR_DRV: drv_d = code;
              default: ph_d = PH_IGN;
            endcase
          end
          default: ph_d = PH_IGN;
        endcase
      end
    end else if (fall && (ph_q == PH_OUT)) begin
      // Load a new byte or keep shifting out
      if (obit_q == 4'h0) begin
        if (opc_q == OP_GETF) begin
          obyte = rd_feat(adr_q, prot_q, cfg_q, status, drv_q);
        end else if (opc_q == OP_RDID) begin
          obyte = idsel_q ? DEV_ID : MFR_ID;
          idsel_d = !idsel_q;
        end else begin
          obyte = buf_v ? buf_dat : 8'hff;
          pop = buf_v;
        end
      end
      case (ln_q)
        5'h02: dqo_d = {2'h0, obyte[7:6]};
        5'h04: dqo_d = obyte[7:4];
        default: dqo_d = {2'h0, obyte[7], 1'b0};
      endcase
      oreg_d = obyte << ln_q[2:0];
      obit_d = ((obit_q == 4'h0) ? 4'h8 : obit_q) - ln_q[3:0];
    end
    if (cs_n_s || (ph_q != PH_OUT)) begin
      idsel_d = 1'b0;
    end
    // Next column follows each accepted cache byte, holding at the last column
    if (CACHE_READY_O && CACHE_VALID_I && (col_q != LAST_COL)) begin
      col_d = col_q + 12'h001;
    end
    // Completion of the array operation
    if (ARR_DONE_I && busy_q) begin
      case (aop_q)
        AOP_READ: ecc_d = ARR_ECC_I;
        AOP_PROG: begin
          pfail_d = ARR_FAIL_I;
          write_enable_latch_d = 1'b0;
        end
        AOP_ERASE: begin
          efail_d = ARR_FAIL_I;
          write_enable_latch_d = 1'b0;
        end
        default: ecc_d = ECC_CLEAN;
      endcase
    end
    busy_d = launch ? 1'b1 : (ARR_DONE_I ? 1'b0 : busy_q);
    start_d = launch;
    case (ln_d)
      5'h02: oe_d = 4'h3;
      5'h04: oe_d = 4'hf;
      default: oe_d = 4'h2;
    endcase
    if (ph_d != PH_OUT) begin
      oe_d = 4'h0;
    end
  end

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sclk_q <= 1'b0;
      ph_q <= PH_CMD;
      aop_q <= AOP_READ;
      cnt_q <= BITS_OPC;
      ln_q <= 5'h01;
      sh_q <= '0;
      opc_q <= 8'h00;
      adr_q <= 8'h00;
      oreg_q <= 8'h00;
      obit_q <= 4'h0;
      dqo_q <= 4'h0;
      oe_q <= 4'h0;
      col_q <= 12'h000;
      row_q <= 16'h0000;
      prot_q <= RST_PROT;
      cfg_q <= RST_CFG;
      drv_q <= RST_DRV;
      ecc_q <= ECC_CLEAN;
      pfail_q <= 1'b0;
      efail_q <= 1'b0;
      write_enable_latch_q <= 1'b0;
      busy_q <= 1'b1;
      start_q <= 1'b0;
      boot_q <= 1'b1;
      idsel_q <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
      ph_q <= ph_d;
      aop_q <= aop_d;
      cnt_q <= cnt_d;
      ln_q <= ln_d;
      sh_q <= sh_d;
      opc_q <= opc_d;
      adr_q <= adr_d;
      oreg_q <= oreg_d;
      obit_q <= obit_d;
      dqo_q <= dqo_d;
      oe_q <= oe_d;
      col_q <= col_d;
      row_q <= row_d;
      prot_q <= prot_d;
      cfg_q <= cfg_d;
      drv_q <= drv_d;
      ecc_q <= ecc_d;
      pfail_q <= pfail_d;
      efail_q <= efail_d;
      write_enable_latch_q <= write_enable_latch_d;
      busy_q <= busy_d;
      start_q <= start_d;
      boot_q <= boot_d;
      idsel_q <= idsel_d;
    end
  end

  // Outputs
  assign DQ_O = dqo_q;
  assign DQ_OE_O = oe_q;
  assign ARR_START_O = start_q;
  assign ARR_OP_O = aop_q;
  assign ARR_ROW_O = row_q;
  assign CACHE_COL_O = col_q;
  assign DRIVE_STRENGTH_O = {drv_q[DRV_HI_BIT], drv_q[DRV_LO_BIT]};
  assign ECC_ENABLE_O = cfg_q[CFG_ECC_EN_BIT];
  assign PROTECT_CFG_O = prot_q;

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!ARST_N_I);

  sequence s_cmd(logic [7:0] c);
    cmd_go && (code == c) && !busy_q;
  endsequence
  sequence s_exec_go;
    launch && ((aop_d == AOP_PROG) || (aop_d == AOP_ERASE));
  endsequence

  a_ecc_reset: assert property (s_cmd(OP_RST) |=> ecc_q == ECC_CLEAN)
    else $error("ecc result not cleared by reset command");
  a_fail_clear: assert property (s_exec_go |=> !pfail_q && !efail_q)
    else $error("fail flags not cleared at execute");
  a_latch_set: assert property (s_cmd(OP_WRITE_ENABLE_CMD) |=>
                                write_enable_latch_q ##1 write_enable_latch_q)
    else $error("write latch not set");
  a_latch_drop: assert property (s_cmd(OP_WRITE_DISABLE_CMD) |=>
                                 !write_enable_latch_q)
    else $error("write latch not cleared");
  a_busy_start: assert property (launch |=> busy_q && start_q
                                 ##1 !start_q)
    else $error("busy or start wrong at launch");
  a_busy_ignore: assert property (cmd_go && busy_q &&
                                  (code == OP_SETF) |=>
                                  ph_q == PH_IGN ##1 !wr_stb)
    else $error("command taken while busy");
  a_drive_set: assert property (wr_stb && (adr_q == ADR_DRV) |=>
                                {1'b0, DRIVE_STRENGTH_O, 5'h00} ==
                                ($past(code) & 8'h60))
    else $error("drive field not taken from set-feature");
  a_status_ro: assert property (wr_stb && (adr_q == ADR_STAT) &&
                                !ARR_DONE_I |=>
                                $stable(write_enable_latch_q))
    else $error("status changed by set-feature");
  a_cs_end: assert property (cs_n_s |=> ph_q == PH_CMD &&
                             oe_q == 4'h0)
    else $error("frame not ended by chip select");
  a_keep_cfg: assert property (s_cmd(OP_RST) |=> $stable(cfg_q))
    else $error("feature changed by reset command");
endmodule

// ---- hdl/snc_sync2.sv ----
`timescale 1ns/100ps
module snc_sync2 import snc_pkg::*; #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Two stages; only the second is read
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= RST;
      sync_q <= RST;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

// ---- shared/snc_pkg.sv ----
package snc_pkg;

  // --------------------------------------------------------------
  // Opcodes
  // --------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] OP_GETF = 8'h0f;
  localparam logic [7:0] OP_SETF = 8'h1f;
  localparam logic [7:0] OP_PRD = 8'h13;
  localparam logic [7:0] OP_RC1 = 8'h03;
  localparam logic [7:0] OP_RCF = 8'h0b;
  localparam logic [7:0] OP_RC2 = 8'h3b;
  localparam logic [7:0] OP_RC4 = 8'h6b;
  localparam logic [7:0] OP_RCD = 8'hbb;
  localparam logic [7:0] OP_RCQ = 8'heb;
  localparam logic [7:0] OP_RDID = 8'h9f;
  localparam logic [7:0] OP_PEXE = 8'h10;
  localparam logic [7:0] OP_BERS = 8'hd8;
  localparam logic [7:0] OP_RST = 8'hff;

  // --------------------------------------------------------------
  // Feature addresses and reset values
  // --------------------------------------------------------------
  localparam logic [7:0] ADR_PROT = 8'ha0;
  localparam logic [7:0] ADR_CFG = 8'hb0;
  localparam logic [7:0] ADR_STAT = 8'hc0;
  localparam logic [7:0] ADR_DRV = 8'hd0;
  localparam logic [7:0] RST_PROT = 8'h7c;
  localparam logic [7:0] RST_CFG = 8'h10;
  localparam logic [7:0] RST_DRV = 8'h00;
  localparam int CFG_ECC_EN_BIT = 4;
  localparam int DRV_HI_BIT = 6;
  localparam int DRV_LO_BIT = 5;

  // --------------------------------------------------------------
  // Field encodings
  // --------------------------------------------------------------
  localparam logic [1:0] ECC_CLEAN = 2'h0;
  localparam logic [1:0] ECC_FIXED = 2'h1;
  localparam logic [1:0] ECC_UNFIX = 2'h2;
  localparam logic [1:0] DRV_FULL = 2'h0;
  localparam logic [1:0] DRV_3Q = 2'h1;
  localparam logic [1:0] DRV_HALF = 2'h2;
  localparam logic [1:0] DRV_1Q = 2'h3;

  // --------------------------------------------------------------
  // Frame bit counts
  // --------------------------------------------------------------
  localparam logic [4:0] BITS_OPC = 5'h08;
  localparam logic [4:0] BITS_FADR = 5'h08;
  localparam logic [4:0] BITS_ROW = 5'h18;
  localparam logic [4:0] BITS_COL = 5'h10;
  localparam logic [4:0] BITS_DUM8 = 5'h08;
  localparam logic [4:0] BITS_DUM16 = 5'h10;
  localparam logic [11:0] LAST_COL = 12'h87f;
  localparam logic [15:0] BOOT_ROW = 16'h0000;

  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_CMD = 3'b000,
    PH_ADDR = 3'b001,
    PH_DUMMY = 3'b010,
    PH_WDATA = 3'b011,
    PH_OUT = 3'b100,
    PH_IGN = 3'b101
  } snc_phase_t;

  typedef enum logic [1:0] {
    AOP_READ = 2'b00,
    AOP_PROG = 2'b01,
    AOP_ERASE = 2'b10,
    AOP_RESET = 2'b11
  } snc_aop_t;

endpackage

// ---- tb/snc_host.sv ----
`timescale 1ns/100ps
// --------
// Host end of the serial link
// --------
module snc_host import snc_pkg::*; (
  // Clock
  input wire logic clk_i,
  // Serial link
  output logic sclk_o,
  output logic cs_n_o,
  output logic dq_o,
  input wire logic [3:0] dq_i
);
  logic [15:0] rd;
  logic [2:0] lines = 3'h1; // Data lines the device answers on
  event got;
  // Idle link: clock low, deselected
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    dq_o = 1'b0;
  end
  // One bit time, data set while the clock is low
  task clk_bit(input logic b);
    sclk_o <= 1'b0;
    dq_o <= b;
    repeat (4) @(posedge clk_i);
    sclk_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
  // Whole frame: opcode, address bits, then read bits
  task frame(input logic [7:0] op, input logic [23:0] a,
    input int na, input int nr);
    cs_n_o <= 1'b0;
    for (int i = 7; i >= 0; i--) clk_bit(op[i]);
    for (int i = na - 1; i >= 0; i--) clk_bit(a[i]);
    rd = 16'h0;
    // Own line keeps toggling while the device talks
    for (int i = 0; i < nr; i++) begin
      clk_bit(~dq_o);
      case (lines)
        3'h4: rd = {rd[11:0], dq_i};
        3'h2: rd = {rd[13:0], dq_i[1:0]};
        default: rd = {rd[14:0], dq_i[1]};
      endcase
    end
    sclk_o <= 1'b0;
    dq_o <= ~dq_o;
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    repeat (12) @(posedge clk_i);
    if (nr > 0) ->got;
  endtask
endmodule

// ---- tb/spi_nand_status_command_core_test.sv ----
`timescale 1ns/100ps
module spi_nand_status_command_core_test import snc_pkg::*;;
  localparam logic [7:0] ID_M = 8'h96; // Arbitrary value
  localparam logic [7:0] ID_D = 8'h69; // Arbitrary value
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic done = 1'b0;
  logic fail = 1'b0;
  logic cvalid = 1'b0;
  logic [1:0] ecc = 2'h0;
  logic [3:0] dq_in, dq, oe;
  logic sclk, cs_n, h_dq, start, ecc_en;
  logic [1:0] op, drv, e;
  logic [15:0] row, r;
  logic [11:0] col, c;
  logic [7:0] pcfg, cdata;
  logic [17:0] la;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [15:0] q_rd[$];
  logic [17:0] q_arr[$];
  // --------
  // Clock, pins and cache source
  // --------
  always #5 clk = ~clk;
  assign dq_in = (oe & dq) | (~oe & {3'h7, h_dq});
  assign cdata = col[7:0] ^ 8'ha5;
  always @(posedge clk) cvalid <= ($urandom % 4) != 0;
  snc_core #(.MFR_ID(ID_M), .DEV_ID(ID_D)) uut (
    .CLOCK_I(clk), .ARST_N_I(arst_n), .SCLK_I(sclk), .CS_N_I(cs_n),
    .DQ_I(dq_in), .DQ_O(dq), .DQ_OE_O(oe), .ARR_START_O(start),
    .ARR_OP_O(op), .ARR_ROW_O(row), .ARR_DONE_I(done),
    .ARR_FAIL_I(fail), .ARR_ECC_I(ecc), .CACHE_COL_O(col),
    .CACHE_DATA_I(cdata), .CACHE_VALID_I(cvalid), .CACHE_READY_O(),
    .DRIVE_STRENGTH_O(drv), .ECC_ENABLE_O(ecc_en),
    .PROTECT_CFG_O(pcfg));
  snc_host host (.clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n),
    .dq_o(h_dq), .dq_i(dq_in));
  // Compare and count
  task chk(input string nm, input logic [17:0] ex, input logic [17:0] g);
    n_compared++;
    if (g !== ex) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, ex, g);
    end
  endtask
  // Verdict and end of run
  task complete_run;
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Serial reads against the oldest note
  always @(host.got)
    chk("read", {2'h0, q_rd.pop_front()}, {2'h0, host.rd});
  // Launches against the oldest note, plus hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      complete_run();
    end
    if (start === 1'b1) begin
      la = q_arr.size() ? q_arr.pop_front() : {~op, 16'h0};
      chk("launch", la,
          {op, la[17:16] == AOP_RESET ? la[15:0] : row});
    end
  end
  // --------
  // Bus helpers
  // --------
  task getf(input logic [7:0] adr, input logic [7:0] ex);
    q_rd.push_back({8'h0, ex});
    host.frame(OP_GETF, {16'h0, adr}, 8, 8);
  endtask
  task setf(input logic [7:0] adr, input logic [7:0] d);
    host.frame(OP_SETF, {8'h0, adr, d}, 16, 0);
  endtask
  task cmd(input logic [7:0] o, input logic [15:0] rw);
    host.frame(o, {8'h0, rw}, (o == OP_PRD || o == OP_BERS ||
      o == OP_PEXE) ? 24 : 0, 0);
  endtask
  task arr_fin(input logic f, input logic [1:0] ec);
    fail <= f;
    ecc <= ec;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    @(posedge clk);
  endtask
  // --------
  // Main sequence
  // --------
  initial begin
    e = 2'($urandom(32'hb90745f5));
    q_arr.push_back({AOP_READ, BOOT_ROW});
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    getf(ADR_STAT, 8'h01);
    q_rd.push_back({ID_M, ID_D});
    host.frame(OP_RDID, 24'h0, 8, 16);
    cmd(OP_WRITE_ENABLE_CMD, 16'h0);
    getf(ADR_STAT, 8'h01);
    e = 2'($urandom % 3);
    arr_fin(1'b0, e);
    getf(ADR_STAT, {2'h0, e, 4'h0});
    getf(ADR_CFG, RST_CFG);
    $display("boot test done");
    for (int i = 0; i < 4; i++) begin
      setf(ADR_DRV, {1'b0, 2'(i), 5'h0});
      chk("drive", 18'(i), {16'h0, drv});
      getf(ADR_DRV, {1'b0, 2'(i), 5'h0});
    end
    r = 16'($urandom);
    setf(ADR_PROT, r[7:0]);
    chk("protect", {10'h0, r[7:0]}, {10'h0, pcfg});
    $display("feature test done");
    cmd(OP_WRITE_ENABLE_CMD, 16'h0);
    getf(ADR_STAT, {2'h0, e, 4'h2});
    setf(ADR_STAT, 8'hff);
    getf(ADR_STAT, {2'h0, e, 4'h2});
    cmd(OP_WRITE_DISABLE_CMD, 16'h0);
    getf(ADR_STAT, {2'h0, e, 4'h0});
    $display("latch test done");
    r = 16'($urandom);
    q_arr.push_back({AOP_READ, r});
    cmd(OP_PRD, r);
    getf(ADR_STAT, {2'h0, e, 4'h1});
    setf(ADR_DRV, 8'h00);
    chk("drive", 18'h3, {16'h0, drv});
    e = 2'($urandom % 3);
    arr_fin(1'b0, e);
    getf(ADR_STAT, {2'h0, e, 4'h0});
    cmd(OP_WRITE_ENABLE_CMD, 16'h0);
    q_arr.push_back({AOP_ERASE, ~r});
    cmd(OP_BERS, ~r);
    arr_fin(1'b1, 2'h0);
    getf(ADR_STAT, {2'h0, e, 4'h4});
    cmd(OP_BERS, r);
    cmd(OP_WRITE_ENABLE_CMD, 16'h0);
    q_arr.push_back({AOP_PROG, r});
    cmd(OP_PEXE, r);
    getf(ADR_STAT, {2'h0, e, 4'h3});
    arr_fin(1'b1, 2'h0);
    getf(ADR_STAT, {2'h0, e, 4'h8});
    $display("array test done");
    q_arr.push_back({AOP_RESET, 16'h0});
    cmd(OP_RST, 16'h0);
    arr_fin(1'b0, 2'h3);
    getf(ADR_STAT, 8'h00);
    getf(ADR_DRV, 8'h60);
    chk("ecc_en", 18'h1, {17'h0, ecc_en});
    $display("reset test done");
    // Single, dual-output, last-column and quad-output reads
    for (int i = 0; i < 4; i++) begin
      c = (i == 2) ? LAST_COL : 12'($urandom % 2175);
      host.lines = (i == 3) ? 3'h4 : (i == 1) ? 3'h2 : 3'h1;
      q_rd.push_back({c[7:0] ^ 8'ha5,
        (c[7:0] + {7'h0, c != LAST_COL}) ^ 8'ha5});
      host.frame(i == 3 ? OP_RC4 : i == 1 ? OP_RC2 : i ? OP_RCF : OP_RC1,
        {4'h0, c, 8'h0}, 24, 16 / host.lines);
    end
    $display("cache test done");
    complete_run();
  end
endmodule
